// ### power_monitor_dev.sv
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
module power_monitor_dev #(
  parameter int unsigned INTERVAL_CYCLES = pm_pkg::INTERVAL_CYC
) (
  // clock and reset
  input  wire logic                                clk,
  input  wire logic                                sys_rst,
  // link to the controller
  pm_link_if.dev                                   link,
  // current channel samples
  input  wire logic        [pm_pkg::SAMPLE_W-1:0]  phase_pos  [pm_pkg::NPHASE],
  input  wire logic signed [pm_pkg::SAMPLE_W-1:0]  phase_diff [pm_pkg::NPHASE],
  // power state
  output logic                                     dsp_run_q,
  output logic                                     serial_en_q,
  output logic                                     capture_en_q,
  output logic                                     circuits_on_q
);
  import pm_pkg::*;

  typedef enum logic [2:0] {ST_XFER, ST_NORMAL, ST_REDUCED, ST_LOW, ST_SLEEP} state_t;
  function automatic state_t state_of(input pmode_t m);
    case (m)
      MODE_NORMAL:  state_of = ST_NORMAL;
      MODE_REDUCED: state_of = ST_REDUCED;
      MODE_LOW:     state_of = ST_LOW;
      default:      state_of = ST_SLEEP;
    endcase
  endfunction : state_of
  function automatic logic [SAMPLE_W-1:0] thresh_of(input logic [LEVEL_W-1:0] lvl);
    logic [SAMPLE_W+LEVEL_W-1:0] prod;
    prod = FULL_SCALE * lvl;
    thresh_of = prod[SAMPLE_W+LEVEL_W-1:LEVEL_W];
  endfunction : thresh_of
  logic [1:0]          pin_s1_q, pin_s2_q;
  state_t              state_q, state_d, want;
  logic [XFER_W-1:0]   xfer_q, xfer_d;
  logic [7:0]          thresh_q, thresh_d;
  logic [DATA_W-1:0]   second_configuration_register_q, second_configuration_register_d;
  logic                lock_q, lock_d, done_q, done_d;
  logic [GAIN_W-1:0]   gain_q, gain_d;
  logic                run_q, run_d, cap_q, cap_d;
  logic [TICK_W-1:0]   tick_q, tick_d;
  logic [PERIOD_W-1:0] per_q, per_d;
  logic                first_interrupt_out_q, first_interrupt_out_d, second_interrupt_out_q, second_interrupt_out_d;
  logic [DATA_W-1:0]   rdata_q, rdata_d;
  logic                serial_d, capture_d, circuits_d;
  logic                period_start, any_hit;
  logic [SAMPLE_W-1:0] thr;
  logic [PERIOD_W-1:0] per_field;
  logic [CNT_W-1:0]    cnt_q [NPHASE];
  logic [MAV_W-1:0]    mav_q [NPHASE];
  logic [NPHASE-1:0]   hit;
  assign per_field = thresh_q[PERIOD_LSB +: PERIOD_W];
  assign thr       = thresh_of(thresh_q[LEVEL_LSB +: LEVEL_W]);
  // mode pins arrive from outside
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_s1_q <= PIN_NORMAL;
      pin_s2_q <= PIN_NORMAL;
    end else begin
      pin_s1_q <= {link.mode_pin_high, link.mode_pin_low};
      pin_s2_q <= pin_s1_q;
    end
  end

  // per-phase peak counters and mean absolute values
    for (genvar p = 0; p < NPHASE; p++) begin : g_phase
      logic                above_q, above_d;
      logic [CNT_W-1:0]    cnt_d;
      logic [MAV_W-1:0]    mav_d;
      logic [SAMPLE_W-1:0] mag;
      always_comb begin
        mag     = phase_diff[p][SAMPLE_W-1] ? SAMPLE_W'(-phase_diff[p]) : phase_diff[p];
        above_d = (phase_pos[p] > thr);
        cnt_d   = cnt_q[p];
        mav_d   = mav_q[p];
        if (state_q != ST_LOW || period_start) begin
          cnt_d = '0;
        end else if (above_d && !above_q && cnt_q[p] != '1) begin
          cnt_d = cnt_q[p] + CNT_W'(1);
        end
        if (state_q == ST_NORMAL || state_q == ST_REDUCED) begin
          mav_d = mav_q[p] - (mav_q[p] >> MAV_SHIFT) + ({mag, 4'h0} >> MAV_SHIFT);
        end
      end
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          above_q  <= 1'b0;
          cnt_q[p] <= '0;
          mav_q[p] <= '0;
        end else begin
          above_q  <= above_d;
          cnt_q[p] <= cnt_d;
          mav_q[p] <= mav_d;
        end
      end
      assign hit[p] = (cnt_q[p] >= CNT_W'(per_field) + CNT_W'(1));
    end
  assign any_hit = |hit;
  always_comb begin
    state_d      = state_q;
    xfer_d       = xfer_q;
    thresh_d     = thresh_q;
    second_configuration_register_d    = second_configuration_register_q;
    lock_d       = lock_q;
    done_d       = done_q;
    gain_d       = gain_q;
    run_d        = run_q;
    cap_d        = cap_q;
    tick_d       = tick_q;
    per_d        = per_q;
    first_interrupt_out_d       = first_interrupt_out_q;
    second_interrupt_out_d       = second_interrupt_out_q;
    rdata_d      = '0;
    period_start = 1'b0;
    want         = state_of(mode_of(pin_s2_q));
    // register access: full in normal, mean values only in reduced
    if (state_q == ST_NORMAL) begin
      if (link.bus_wr) begin
        case (link.bus_addr)
          REG_THRESH:  thresh_d = link.bus_wdata[7:0];
          REG_SECOND_CONFIGURATION_REGISTER: begin
            second_configuration_register_d = link.bus_wdata;
            if (link.bus_wdata[LOCK_BIT]) lock_d = 1'b1;
          end
          REG_STATUS:  if (link.bus_wdata[DONE_BIT]) done_d = 1'b0;
          REG_GAIN:    gain_d = link.bus_wdata[GAIN_W-1:0];
          REG_RUN:     run_d = link.bus_wdata[RUN_BIT];
          REG_CONFIG:  cap_d = link.bus_wdata[CAP_BIT];
          REG_SWRST: if (link.bus_wdata[SWRST_BIT]) begin
            gain_d = '0;
            run_d  = 1'b0;
            cap_d  = 1'b0;
            done_d = 1'b0;
          end
          default: ;
        endcase
      end
      if (link.bus_rd) begin
        case (link.bus_addr)
          REG_THRESH:  rdata_d = {8'h00, thresh_q};
          REG_SECOND_CONFIGURATION_REGISTER: rdata_d = second_configuration_register_q;
          REG_STATUS:  rdata_d = {done_q, 15'h0000};
          REG_GAIN:    rdata_d = DATA_W'(gain_q);
          REG_RUN:     rdata_d = DATA_W'(run_q);
          REG_CONFIG:  rdata_d = DATA_W'(cap_q) << CAP_BIT;
          default: ;
        endcase
      end
    end
    if ((state_q == ST_NORMAL || state_q == ST_REDUCED) && link.bus_rd &&
        link.bus_addr >= REG_MAV_A && link.bus_addr <= REG_MAV_TOP) begin
      rdata_d = mav_q[2'(link.bus_addr - REG_MAV_A)][MAV_W-1 -: DATA_W];
    end
    // mode sequencing
    if (want != state_q && !(state_q == ST_XFER && want == ST_NORMAL)) begin
      if (want == ST_NORMAL) begin
        state_d = ST_XFER;
        xfer_d  = '0;
        gain_d  = '0;
        run_d   = 1'b0;
        cap_d   = 1'b0;
        done_d  = 1'b0;
      end else begin
        state_d = want;
      end
      if (want == ST_LOW) begin
        period_start = 1'b1;
        tick_d       = '0;
        per_d        = '0;
        first_interrupt_out_d       = 1'b1;
        second_interrupt_out_d       = 1'b1;
      end
    end else if (state_q == ST_XFER) begin
      if (xfer_q == XFER_W'(XFER_CYC - 1)) begin
        state_d = ST_NORMAL;
        done_d  = 1'b1;
      end else begin
        xfer_d = xfer_q + XFER_W'(1);
      end
    end else if (state_q == ST_LOW) begin
      if (tick_q == TICK_W'(INTERVAL_CYCLES - 1)) begin
        tick_d = '0;
        if (per_q == per_field) begin
          period_start = 1'b1;
          per_d        = '0;
          if (any_hit) second_interrupt_out_d = 1'b0;
          else         first_interrupt_out_d = 1'b0;
        end else begin
          per_d = per_q + PERIOD_W'(1);
        end
      end else begin
        tick_d = tick_q + TICK_W'(1);
      end
    end
    if (state_d == ST_NORMAL || state_d == ST_XFER) begin
      first_interrupt_out_d = 1'b1;
      second_interrupt_out_d = !done_d;
    end else if (state_d != ST_LOW) begin
      first_interrupt_out_d = 1'b1;
      second_interrupt_out_d = 1'b1;
    end
    serial_d   = (state_d == ST_NORMAL || state_d == ST_REDUCED);
    capture_d  = (state_d == ST_NORMAL) && cap_d;
    circuits_d = (state_d != ST_SLEEP);
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q       <= ST_XFER;
      xfer_q        <= '0;
      thresh_q      <= THRESH_RST;
      second_configuration_register_q     <= '0;
      lock_q        <= 1'b0;
      done_q        <= 1'b0;
      gain_q        <= '0;
      run_q         <= 1'b0;
      cap_q         <= 1'b0;
      tick_q        <= '0;
      per_q         <= '0;
      first_interrupt_out_q        <= 1'b1;
      second_interrupt_out_q        <= 1'b1;
      rdata_q       <= '0;
      dsp_run_q     <= 1'b0;
      serial_en_q   <= 1'b1;
      capture_en_q  <= 1'b0;
      circuits_on_q <= 1'b1;
    end else begin
      state_q       <= state_d;
      xfer_q        <= xfer_d;
      thresh_q      <= thresh_d;
      second_configuration_register_q     <= second_configuration_register_d;
      lock_q        <= lock_d;
      done_q        <= done_d;
      gain_q        <= gain_d;
      run_q         <= run_d;
      cap_q         <= cap_d;
      tick_q        <= tick_d;
      per_q         <= per_d;
      first_interrupt_out_q        <= first_interrupt_out_d;
      second_interrupt_out_q        <= second_interrupt_out_d;
      rdata_q       <= rdata_d;
      dsp_run_q     <= run_d;
      serial_en_q   <= serial_d;
      capture_en_q  <= capture_d;
      circuits_on_q <= circuits_d;
    end
  end
  assign link.first_interrupt_out_n  = first_interrupt_out_q;
  assign link.second_interrupt_out_n = second_interrupt_out_q;
  assign link.bus_rdata              = rdata_q;
endmodule : power_monitor_dev

// ### pm_pkg.sv
package pm_pkg;

  // mode pin pairs {mode_pin_high, mode_pin_low}
  localparam logic [1:0] PIN_REDUCED = 2'h0;
  localparam logic [1:0] PIN_NORMAL  = 2'h1;
  localparam logic [1:0] PIN_LOW     = 2'h2;
  localparam logic [1:0] PIN_SLEEP   = 2'h3;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_REDUCED,
    MODE_LOW,
    MODE_SLEEP
  } pmode_t;

  // device register map
  localparam int           ADDR_W      = 8;
  localparam int           DATA_W      = 16;
  localparam logic [7:0]   REG_THRESH  = 8'h00;
  localparam logic [7:0]   REG_SECOND_CONFIGURATION_REGISTER = 8'h01;
  localparam logic [7:0]   REG_STATUS  = 8'h02;
  localparam logic [7:0]   REG_GAIN    = 8'h03;
  localparam logic [7:0]   REG_RUN     = 8'h04;
  localparam logic [7:0]   REG_SWRST   = 8'h05;
  localparam logic [7:0]   REG_CONFIG  = 8'h06;
  localparam logic [7:0]   REG_MAV_A   = 8'h08;
  localparam logic [7:0]   REG_MAV_TOP = 8'h0A;
  localparam logic [7:0]   THRESH_RST  = 8'h07;
  localparam int           LEVEL_LSB   = 0;
  localparam int           LEVEL_W     = 3;
  localparam int           PERIOD_LSB  = 3;
  localparam int           PERIOD_W    = 5;
  localparam int           DONE_BIT    = 15;
  localparam int           LOCK_BIT    = 1;
  localparam int           SWRST_BIT   = 0;
  localparam int           RUN_BIT     = 0;
  localparam int           CAP_BIT     = 6;
  localparam int           GAIN_W      = 3;

  // datapath
  localparam int           NPHASE      = 3;
  localparam int           SAMPLE_W    = 16;
  localparam int           MAV_W       = 20;
  localparam int           MAV_SHIFT   = 6;
  localparam int           CNT_W       = 6;
  localparam logic [15:0]  FULL_SCALE  = 16'hFFFF;

  // timing
  localparam int           CLK_NS       = 100;
  localparam int           INTERVAL_NS  = 20_000_000;
  localparam int           INTERVAL_CYC = INTERVAL_NS / CLK_NS;
  localparam int           TICK_W       = 18;
  localparam int           XFER_CYC     = 16;
  localparam int           XFER_W       = 5;

  // controller register map
  localparam logic [7:0]   H_MODE   = 8'h00;
  localparam logic [7:0]   H_STATUS = 8'h01;
  localparam logic [7:0]   H_LADDR  = 8'h02;
  localparam logic [7:0]   H_LWDATA = 8'h03;
  localparam logic [7:0]   H_LCMD   = 8'h04;
  localparam logic [7:0]   H_LRDATA = 8'h05;
  localparam logic [7:0]   H_CTRL   = 8'h06;
  localparam int           AUTO_BIT = 0;
  localparam int           GAIN_LSB = 1;
  localparam int           CMD_WR   = 0;
  localparam int           CMD_RD   = 1;
  localparam int           ST_FIRST_INTERRUPT_OUT  = 0;
  localparam int           ST_SECOND_INTERRUPT_OUT  = 1;
  localparam int           ST_REFUS = 2;
  localparam int           ST_SEEN0 = 3;
  localparam int           ST_SEEN1 = 4;
  localparam logic [2:0]   GAIN_ONE = 3'h1;
  localparam logic [2:0]   GAIN_TWO = 3'h2;

  function automatic pmode_t mode_of(input logic [1:0] pins);
    case (pins)
      PIN_NORMAL:  mode_of = MODE_NORMAL;
      PIN_REDUCED: mode_of = MODE_REDUCED;
      PIN_LOW:     mode_of = MODE_LOW;
      default:     mode_of = MODE_SLEEP;
    endcase
  endfunction : mode_of

endpackage : pm_pkg

// ### pm_link_if.sv
`timescale 1ns/1ps
interface pm_link_if (input wire logic clk);
  import pm_pkg::*;
  logic                mode_pin_low;
  logic                mode_pin_high;
  logic                first_interrupt_out_n;
  logic                second_interrupt_out_n;
  logic [ADDR_W-1:0]   bus_addr;
  logic [DATA_W-1:0]   bus_wdata;
  logic                bus_wr;
  logic                bus_rd;
  logic [DATA_W-1:0]   bus_rdata;

  modport dev (
    input  mode_pin_low, mode_pin_high, bus_addr, bus_wdata, bus_wr, bus_rd,
    output first_interrupt_out_n, second_interrupt_out_n, bus_rdata
  );
  modport host (
    output mode_pin_low, mode_pin_high, bus_addr, bus_wdata, bus_wr, bus_rd,
    input  first_interrupt_out_n, second_interrupt_out_n, bus_rdata
  );
endinterface : pm_link_if

// ### power_ctrl_host.sv
`timescale 1ns/1ps
module power_ctrl_host (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  // link to the device
  pm_link_if.host                         link,
  // software port
  input  wire logic [pm_pkg::ADDR_W-1:0]  sw_addr,
  input  wire logic [pm_pkg::DATA_W-1:0]  sw_wdata,
  input  wire logic                       sw_wr,
  input  wire logic                       sw_rd,
  output logic      [pm_pkg::DATA_W-1:0]  sw_rdata_q
);
  import pm_pkg::*;

  logic [1:0]        irq_s1_q, irq_s2_q, irq_s3_q;
  logic [1:0]        pins_q, pins_d;
  logic [DATA_W-1:0] ctrl_q, ctrl_d;
  logic [DATA_W-1:0] laddr_q, laddr_d;
  logic [DATA_W-1:0] lwdata_q, lwdata_d;
  logic [DATA_W-1:0] lrdata_q, lrdata_d;
  logic              refus_q, refus_d;
  logic              seen0_q, seen0_d;
  logic              seen1_q, seen1_d;
  logic              bwr_q, bwr_d;
  logic              brd_q, brd_d;
  logic              rpend_q, rpend_d;
  logic [DATA_W-1:0] sw_rdata_d;
  logic              fall0, fall1, gain_ok;
  pmode_t            cur;

  // interrupt pins arrive from outside
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_s1_q <= 2'h3;
      irq_s2_q <= 2'h3;
      irq_s3_q <= 2'h3;
    end else begin
      irq_s1_q <= {link.second_interrupt_out_n, link.first_interrupt_out_n};
      irq_s2_q <= irq_s1_q;
      irq_s3_q <= irq_s2_q;
    end
  end

  assign fall0   = irq_s3_q[0] && !irq_s2_q[0];
  assign fall1   = irq_s3_q[1] && !irq_s2_q[1];
  assign cur     = mode_of(pins_q);
  assign gain_ok = (ctrl_q[GAIN_LSB +: GAIN_W] == GAIN_ONE) ||
                   (ctrl_q[GAIN_LSB +: GAIN_W] == GAIN_TWO);

  always_comb begin
    pins_d     = pins_q;
    ctrl_d     = ctrl_q;
    laddr_d    = laddr_q;
    lwdata_d   = lwdata_q;
    lrdata_d   = lrdata_q;
    refus_d    = refus_q;
    seen0_d    = seen0_q;
    seen1_d    = seen1_q;
    bwr_d      = 1'b0;
    brd_d      = 1'b0;
    rpend_d    = brd_q;
    sw_rdata_d = '0;
    if (rpend_q) lrdata_d = link.bus_rdata;
    if (sw_wr) begin
      case (sw_addr)
        H_MODE: begin
          if (mode_of(sw_wdata[1:0]) == MODE_LOW && !gain_ok) begin
            refus_d = 1'b1;
          end else begin
            pins_d = sw_wdata[1:0];
          end
        end
        H_STATUS: begin
          if (sw_wdata[ST_REFUS]) refus_d = 1'b0;
          if (sw_wdata[ST_SEEN0]) seen0_d = 1'b0;
          if (sw_wdata[ST_SEEN1]) seen1_d = 1'b0;
        end
        H_LADDR:  laddr_d = sw_wdata;
        H_LWDATA: lwdata_d = sw_wdata;
        H_LCMD: begin
          if (cur != MODE_SLEEP) begin
            bwr_d = sw_wdata[CMD_WR];
            brd_d = sw_wdata[CMD_RD] && !sw_wdata[CMD_WR];
          end
        end
        H_CTRL:   ctrl_d = sw_wdata;
        default: ;
      endcase
    end
    if (sw_rd) begin
      case (sw_addr)
        H_MODE:   sw_rdata_d = DATA_W'(pins_q);
        H_STATUS: sw_rdata_d = DATA_W'({seen1_q, seen0_q, refus_q,
                                        irq_s2_q[1], irq_s2_q[0]});
        H_LADDR:  sw_rdata_d = laddr_q;
        H_LWDATA: sw_rdata_d = lwdata_q;
        H_LRDATA: sw_rdata_d = lrdata_q;
        H_CTRL:   sw_rdata_d = ctrl_q;
        default: ;
      endcase
    end
    // events win over software clears
    if (fall0) seen0_d = 1'b1;
    if (fall1) seen1_d = 1'b1;
    if (ctrl_q[AUTO_BIT] && cur == MODE_LOW) begin
      if (fall1)      pins_d = PIN_REDUCED;
      else if (fall0) pins_d = PIN_SLEEP;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pins_q     <= PIN_NORMAL;
      ctrl_q     <= '0;
      laddr_q    <= '0;
      lwdata_q   <= '0;
      lrdata_q   <= '0;
      refus_q    <= 1'b0;
      seen0_q    <= 1'b0;
      seen1_q    <= 1'b0;
      bwr_q      <= 1'b0;
      brd_q      <= 1'b0;
      rpend_q    <= 1'b0;
      sw_rdata_q <= '0;
    end else begin
      pins_q     <= pins_d;
      ctrl_q     <= ctrl_d;
      laddr_q    <= laddr_d;
      lwdata_q   <= lwdata_d;
      lrdata_q   <= lrdata_d;
      refus_q    <= refus_d;
      seen0_q    <= seen0_d;
      seen1_q    <= seen1_d;
      bwr_q      <= bwr_d;
      brd_q      <= brd_d;
      rpend_q    <= rpend_d;
      sw_rdata_q <= sw_rdata_d;
    end
  end

  assign link.mode_pin_low  = pins_q[0];
  assign link.mode_pin_high = pins_q[1];
  assign link.bus_addr      = laddr_q[ADDR_W-1:0];
  assign link.bus_wdata     = lwdata_q;
  assign link.bus_wr        = bwr_q;
  assign link.bus_rd        = brd_q;

endmodule : power_ctrl_host

// ### pm_link_monitor.sv
`timescale 1ns/1ps
module pm_link_monitor #(
  parameter int unsigned INTERVAL_CYCLES = pm_pkg::INTERVAL_CYC
) (
  // clock and reset
  input wire logic                      clk,
  input wire logic                      sys_rst,
  // link signals
  input wire logic                      mode_pin_low,
  input wire logic                      mode_pin_high,
  input wire logic                      first_interrupt_out_n,
  input wire logic                      second_interrupt_out_n,
  input wire logic [pm_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [pm_pkg::DATA_W-1:0] bus_wdata,
  input wire logic                      bus_wr,
  input wire logic                      bus_rd,
  input wire logic [pm_pkg::DATA_W-1:0] bus_rdata
);
  import pm_pkg::*;
  logic [1:0]  pins;
  logic [1:0]  pins_q;
  logic [7:0]  st_q;
  logic [15:0] lp_q;
  logic [7:0]  thr_q;
  int          span;
  assign pins = {mode_pin_high, mode_pin_low};
  assign span = (int'(thr_q[7:3]) + 1) * int'(INTERVAL_CYCLES);
  // pin stability, time in low power, last threshold written
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pins_q <= PIN_NORMAL;
      st_q   <= 8'h00;
      lp_q   <= 16'h0000;
      thr_q  <= THRESH_RST;
    end else begin
      pins_q <= pins;
      st_q   <= (pins != pins_q) ? 8'h00 : ((st_q == 8'hff) ? st_q : st_q + 8'h01);
      lp_q   <= (pins == PIN_LOW) ? lp_q + 16'h0001 : 16'h0000;
      if (bus_wr && bus_addr == REG_THRESH && pins == PIN_NORMAL && st_q > 8'd40) begin
        thr_q <= bus_wdata[7:0];
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_lp_read_zero: assert property (bus_rd && pins == PIN_LOW && st_q > 8'd4 |=> bus_rdata == 16'h0000)
    else $error("read answered in low power");
  a_reduced_read_limit: assert property (bus_rd && pins == PIN_REDUCED && st_q > 8'd4 && bus_addr < REG_MAV_A |=> bus_rdata == 16'h0000)
    else $error("reduced power read of a held register");
  a_first_irq_mode: assert property ($fell(first_interrupt_out_n) |-> pins == PIN_LOW)
    else $error("first interrupt outside low power");
  a_period_span: assert property (($fell(first_interrupt_out_n) || $fell(second_interrupt_out_n)) && pins == PIN_LOW |-> int'(lp_q) >= span && (int'(lp_q) % span) <= 8)
    else $error("low power result at wrong time");
  a_first_irq_hold: assert property (!first_interrupt_out_n && pins == PIN_LOW && st_q > 8'd4 |=> !first_interrupt_out_n)
    else $error("first interrupt released in low power");
  a_one_outcome: assert property (!($fell(first_interrupt_out_n) && $fell(second_interrupt_out_n)))
    else $error("both interrupts at one period end");
  a_done_delay: assert property ($fell(second_interrupt_out_n) && pins == PIN_NORMAL |-> st_q >= 8'd14 && st_q <= 8'd26)
    else $error("transition end at wrong time");
  a_done_clear: assert property (bus_wr && bus_addr == REG_STATUS && bus_wdata[DONE_BIT] && pins == PIN_NORMAL && st_q > 8'd40 |-> ##[1:3] second_interrupt_out_n)
    else $error("done clear left second interrupt low");
endmodule : pm_link_monitor

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import pm_pkg::*;
  localparam int unsigned N = 20;
  logic                       clk;
  logic                       sys_rst;
  logic        [ADDR_W-1:0]   sw_addr;
  logic        [DATA_W-1:0]   sw_wdata;
  logic                       sw_wr;
  logic                       sw_rd;
  logic        [DATA_W-1:0]   sw_rdata_q;
  logic        [SAMPLE_W-1:0] phase_pos  [NPHASE];
  logic signed [SAMPLE_W-1:0] phase_diff [NPHASE];
  logic                       dsp_run_q;
  logic                       serial_en_q;
  logic                       capture_en_q;
  logic                       circuits_on_q;
  logic        [15:0]         swing;
  int                         miscompares;
  int                         cmp_count;
  int                         cyc;
  pm_link_if link (.clk(clk));
  power_monitor_dev #(.INTERVAL_CYCLES(N)) power_monitor_dev_inst (.clk(clk), .sys_rst(sys_rst),
    .link(link), .phase_pos(phase_pos), .phase_diff(phase_diff), .dsp_run_q(dsp_run_q),
    .serial_en_q(serial_en_q), .capture_en_q(capture_en_q), .circuits_on_q(circuits_on_q));
  power_ctrl_host power_ctrl_host_inst (.clk(clk), .sys_rst(sys_rst), .link(link),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata_q(sw_rdata_q));
  pm_link_monitor #(.INTERVAL_CYCLES(N)) pm_link_monitor_inst (.clk(clk), .sys_rst(sys_rst),
    .mode_pin_low(link.mode_pin_low), .mode_pin_high(link.mode_pin_high),
    .first_interrupt_out_n(link.first_interrupt_out_n),
    .second_interrupt_out_n(link.second_interrupt_out_n), .bus_addr(link.bus_addr),
    .bus_wdata(link.bus_wdata), .bus_wr(link.bus_wr), .bus_rd(link.bus_rd),
    .bus_rdata(link.bus_rdata));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  // phase inputs swing every 4 cycles; cycle ceiling
  always @(posedge clk) begin
    cyc <= cyc + 1;
    for (int i = 0; i < NPHASE; i++) begin
      phase_pos[i]  <= cyc[2] ? swing : 16'h0000;
      phase_diff[i] <= cyc[2] ? 16'sh7fff : 16'sh8001;
    end
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic sw_w(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_wr    <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
    #1;
  endtask : sw_w
  task automatic sw_r(input logic [7:0] a, input logic [15:0] m, output logic [15:0] v);
    @(posedge clk);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 v = sw_rdata_q & m;
  endtask : sw_r
  task automatic lw(input logic [7:0] a, input logic [15:0] d);
    sw_w(H_LADDR, {8'h00, a});
    sw_w(H_LWDATA, d);
    sw_w(H_LCMD, 16'h0001);
    repeat (3) @(posedge clk);
  endtask : lw
  // device read through the controller, masked compare
  task automatic lr(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e,
                    output logic [15:0] v);
    sw_w(H_LADDR, {8'h00, a});
    sw_w(H_LCMD, 16'h0002);
    repeat (3) @(posedge clk);
    sw_r(H_LRDATA, m, v);
    chk(v, e);
  endtask : lr
  task automatic wait_low(input logic sel);
    int n;
    n = 0;
    while (n < 400 && (sel ? link.second_interrupt_out_n : link.first_interrupt_out_n) !== 1'b0) begin
      @(posedge clk);
      n++;
    end
    #1;
  endtask : wait_low
  function automatic logic [15:0] pins_now();
    return {14'h0000, link.mode_pin_high, link.mode_pin_low};
  endfunction : pins_now
  initial begin
    logic [15:0] v;
    sys_rst = 1'b1;
    sw_addr = 8'h00;
    sw_wdata = 16'h0000;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    swing = 16'h0000;
    cyc = 0;
    miscompares = 0;
    cmp_count = 0;
    for (int i = 0; i < NPHASE; i++) begin
      phase_pos[i] = 16'h0000;
      phase_diff[i] = 16'sh0000;
    end
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    wait_low(1'b1);
    chk(16'(link.second_interrupt_out_n), 16'h0000);
    lr(REG_THRESH, 16'hffff, 16'h0007, v);
    lr(REG_STATUS, 16'h8000, 16'h8000, v);
    chk({14'h0000, serial_en_q, dsp_run_q}, 16'h0002);
    lw(REG_STATUS, 16'h8000);
    chk(16'(link.second_interrupt_out_n), 16'h0001);
    sw_r(8'h0f, 16'hffff, v);
    chk(v, 16'h0000);
    lw(REG_THRESH, 16'h000c);
    lw(REG_SECOND_CONFIGURATION_REGISTER, 16'h0002);
    lw(REG_RUN, 16'h0001);
    chk(16'(dsp_run_q), 16'h0001);
    lw(REG_SWRST, 16'h0001);
    lr(REG_THRESH, 16'hffff, 16'h000c, v);
    lr(REG_SECOND_CONFIGURATION_REGISTER, 16'hffff, 16'h0002, v);
    lr(REG_RUN, 16'hffff, 16'h0000, v);
    lw(REG_CONFIG, 16'h0040);
    chk(16'(capture_en_q), 16'h0001);
    sw_w(H_CTRL, 16'h0009);
    sw_w(H_MODE, 16'h0002);
    chk(pins_now(), 16'h0001);
    sw_r(H_STATUS, 16'h0004, v);
    chk(v, 16'h0004);
    sw_w(H_STATUS, 16'h0004);
    sw_r(H_STATUS, 16'h0004, v);
    chk(v, 16'h0000);
    // no current: level 4 of 8, peaks stop exactly at threshold
    sw_w(H_CTRL, 16'h0003);
    swing = 16'h7fff;
    sw_w(H_MODE, 16'h0002);
    repeat (5) @(posedge clk);
    chk(pins_now(), 16'h0002);
    chk(16'(serial_en_q), 16'h0000);
    lr(REG_THRESH, 16'hffff, 16'h0000, v);
    wait_low(1'b0);
    chk(16'(link.first_interrupt_out_n), 16'h0000);
    chk(16'(link.second_interrupt_out_n), 16'h0001);
    repeat (8) @(posedge clk);
    chk(pins_now(), 16'h0003);
    chk({13'h0000, circuits_on_q, serial_en_q, capture_en_q}, 16'h0000);
    sw_w(H_MODE, 16'h0001);
    wait_low(1'b1);
    chk(16'(link.second_interrupt_out_n), 16'h0000);
    lr(REG_THRESH, 16'hffff, 16'h000c, v);
    lr(REG_SECOND_CONFIGURATION_REGISTER, 16'hffff, 16'h0002, v);
    lr(REG_CONFIG, 16'hffff, 16'h0000, v);
    lw(REG_STATUS, 16'h8000);
    // current flowing: peaks just above threshold
    swing = 16'h8000;
    sw_w(H_MODE, 16'h0002);
    wait_low(1'b1);
    chk(16'(link.second_interrupt_out_n), 16'h0000);
    chk(16'(link.first_interrupt_out_n), 16'h0001);
    repeat (8) @(posedge clk);
    chk(pins_now(), 16'h0000);
    repeat (40) @(posedge clk);
    chk(16'(serial_en_q), 16'h0001);
    lr(REG_THRESH, 16'hffff, 16'h0000, v);
    lr(REG_MAV_A, 16'hc000, 16'h4000, v);
    sw_r(H_LRDATA, 16'hffff, v);
    chk(16'(v != 16'h0000), 16'h0001);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    wait_low(1'b1);
    lr(REG_THRESH, 16'hffff, 16'h0007, v);
    lr(REG_SECOND_CONFIGURATION_REGISTER, 16'hffff, 16'h0000, v);
    results();
  end
endmodule : tb_top
